/* rtl/sto_pkg.sv */
package sto_pkg;

    // ****************************************
    // register map (apb byte addresses)
    // ****************************************
    localparam logic [7:0] STO_CTRL_OFF   = 8'h00;
    localparam logic [7:0] STO_STATUS_OFF = 8'h04;
    localparam logic [7:0] STO_TERM_OFF   = 8'h08;
    localparam logic [7:0] STO_IRQ_ST_OFF = 8'h0c;
    localparam logic [7:0] STO_IRQ_EN_OFF = 8'h10;
    localparam logic [7:0] STO_IRQ_CL_OFF = 8'h14;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_SAFE_SW   = 2;
    localparam int CTRL_MON_SW    = 3;
    localparam int CTRL_EXT_TRIP  = 4;
    localparam int CTRL_TRIP_CLR  = 5;

    // ****************************************
    // terminal register fields
    // ****************************************
    localparam int TERM_IN3_FN_LSB  = 0;
    localparam int TERM_IN4_FN_LSB  = 8;
    localparam int TERM_OUT11_FN_LSB = 16;
    localparam int TERM_IN3_ACT     = 24;
    localparam int TERM_IN4_ACT     = 25;
    localparam int TERM_OUT11_ACT   = 26;

    // ****************************************
    // setting codes
    // ****************************************
    localparam logic [1:0] MODE_NO_TRIP   = 2'h0;
    localparam logic [1:0] MODE_TRIP      = 2'h1;
    localparam logic [7:0] FN_SAFE_A      = 8'h4d;   // decimal 77
    localparam logic [7:0] FN_SAFE_B      = 8'h4e;   // decimal 78
    localparam logic [7:0] FN_DEV_MON     = 8'h3e;   // decimal 62
    localparam logic [7:0] FN_NONE        = 8'hff;
    localparam logic       ACT_NC         = 1'h1;    // setting 01
    localparam logic       ACT_NO         = 1'h0;    // setting 00
    localparam logic [7:0] TRIP_NONE      = 8'h00;
    localparam logic [7:0] SAFE_STOP_TRIP_CODE = 8'h25; // decimal 37
    localparam logic [7:0] EXTERNAL_TRIP_CODE  = 8'h0c; // decimal 12

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [1:0] CTRL_MODE_RST  = 2'h0;
    localparam int         CORE_CLK_MHZ   = 200;
    localparam int         CUTOFF_MAX_MS  = 10;
    localparam int         CUTOFF_MAX_CYC = CUTOFF_MAX_MS * CORE_CLK_MHZ * 1000;

    // ****************************************
    // interrupt bits
    // ****************************************
    localparam int IRQ_W        = 3;
    localparam int IRQ_TRIP     = 0;
    localparam int IRQ_CUT      = 1;
    localparam int IRQ_ONE_CHAN = 2;

    typedef enum logic [2:0] {
        STO_RUN     = 3'b001,
        STO_STOPPED = 3'b010,
        STO_TRIPPED = 3'b100
    } sto_state_type;

endpackage

/* rtl/sto_sync.sv */
`timescale 1ns/10ps
module sto_sync
    import sto_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    // data
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // first stage feeds only the second one
    always_comb begin
        next_stage1 = async_i;
        next_stage2 = stage1;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_o = stage2;
endmodule

/* rtl/sto_irq.sv */
`timescale 1ns/10ps
module sto_irq
    import sto_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // events and software access
    input  wire logic [IRQ_W-1:0] event_i,
    input  wire logic [IRQ_W-1:0] clear_i,
    input  wire logic             en_we_i,
    input  wire logic [IRQ_W-1:0] en_wdata_i,
    output logic [IRQ_W-1:0]      status_o,
    output logic [IRQ_W-1:0]      enable_o,
    output logic                  irq_o
);
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
    logic [IRQ_W-1:0] next_status;
    logic [IRQ_W-1:0] next_enable;

    // set wins over a clear in the same cycle
    always_comb begin
        next_status = (status & ~clear_i) | event_i;
        next_enable = en_we_i ? en_wdata_i : enable;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status <= '0;
            enable <= '0;
        end else begin
            status <= next_status;
            enable <= next_enable;
        end
    end

    assign status_o = status;
    assign enable_o = enable;
    assign irq_o    = |(status & enable);
endmodule

/* rtl/sto_interlock.sv */
`timescale 1ns/10ps
module sto_interlock
    import sto_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // safety channels, high while current flows
    input  wire logic        safe_channel_a_i,
    input  wire logic        safe_channel_b_i,
    // power stage gating request and result
    input  wire logic        gate_run_i,
    output logic             gate_enable_o,
    // monitor output and trip
    output logic             device_monitor_out_o,
    output logic [7:0]       trip_code_o,
    output logic             irq_o
);

    // ****************************************
    // bus decode
    // ****************************************
    logic wr_access;
    logic rd_access;
    logic addr_ok;

    function automatic logic sto_hit(input logic [7:0] addr, input logic [7:0] off);
        sto_hit = (addr == off);
    endfunction

    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & penable & ~pwrite;
    assign addr_ok   = sto_hit(paddr, STO_CTRL_OFF) | sto_hit(paddr, STO_STATUS_OFF) |
                       sto_hit(paddr, STO_TERM_OFF) | sto_hit(paddr, STO_IRQ_ST_OFF) |
                       sto_hit(paddr, STO_IRQ_EN_OFF) | sto_hit(paddr, STO_IRQ_CL_OFF);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~addr_ok;

    // ****************************************
    // control and terminal assignment state
    // ****************************************
    logic [1:0] safe_input_mode_setting;
    logic       safety_switch;
    logic       monitor_switch;
    logic       ext_trip;
    logic [7:0] input3_function_select;
    logic [7:0] input4_function_select;
    logic [7:0] output11_function_select;
    logic       in3_active;
    logic       in4_active;
    logic       out11_active;
    logic [1:0] next_mode;
    logic       next_safety_switch;
    logic       next_monitor_switch;
    logic       next_ext_trip;
    logic [7:0] next_in3_fn;
    logic [7:0] next_in4_fn;
    logic [7:0] next_out11_fn;
    logic       next_in3_act;
    logic       next_in4_act;
    logic       next_out11_act;
    logic       trip_clr_req;
    logic       term_wr;

    assign term_wr      = wr_access & sto_hit(paddr, STO_TERM_OFF);
    assign trip_clr_req = wr_access & sto_hit(paddr, STO_CTRL_OFF) & pwdata[CTRL_TRIP_CLR];

    always_comb begin
        next_mode           = safe_input_mode_setting;
        next_safety_switch  = safety_switch;
        next_monitor_switch = monitor_switch;
        next_ext_trip       = ext_trip;
        next_in3_fn         = input3_function_select;
        next_in4_fn         = input4_function_select;
        next_out11_fn       = output11_function_select;
        next_in3_act        = in3_active;
        next_in4_act        = in4_active;
        next_out11_act      = out11_active;
        if (wr_access && sto_hit(paddr, STO_CTRL_OFF)) begin
            next_mode           = pwdata[CTRL_MODE_LSB +: 2];
            next_safety_switch  = pwdata[CTRL_SAFE_SW];
            next_monitor_switch = pwdata[CTRL_MON_SW];
            next_ext_trip       = pwdata[CTRL_EXT_TRIP];
        end
        // writes land only on assignments the switches do not own
        if (term_wr && !safety_switch) begin
            next_in3_fn  = pwdata[TERM_IN3_FN_LSB +: 8];
            next_in4_fn  = pwdata[TERM_IN4_FN_LSB +: 8];
            next_in3_act = pwdata[TERM_IN3_ACT];
            next_in4_act = pwdata[TERM_IN4_ACT];
        end
        if (term_wr && !monitor_switch) begin
            next_out11_fn  = pwdata[TERM_OUT11_FN_LSB +: 8];
            next_out11_act = pwdata[TERM_OUT11_ACT];
        end
        // switch on forces the safety assignments
        if (next_safety_switch) begin
            next_in3_fn  = FN_SAFE_A;
            next_in4_fn  = FN_SAFE_B;
            next_in3_act = ACT_NC;
            next_in4_act = ACT_NC;
        end else if (safety_switch) begin
            next_in3_fn  = FN_NONE;
            next_in4_fn  = FN_NONE;
            next_in3_act = ACT_NO;
            next_in4_act = ACT_NO;
        end
        if (next_monitor_switch) begin
            next_out11_fn  = FN_DEV_MON;
            next_out11_act = ACT_NO;
        end else if (monitor_switch) begin
            next_out11_fn  = FN_NONE;
            next_out11_act = ACT_NO;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            safe_input_mode_setting  <= CTRL_MODE_RST;
            safety_switch            <= 1'b0;
            monitor_switch           <= 1'b0;
            ext_trip                 <= 1'b0;
            input3_function_select   <= FN_NONE;
            input4_function_select   <= FN_NONE;
            output11_function_select <= FN_NONE;
            in3_active               <= ACT_NO;
            in4_active               <= ACT_NO;
            out11_active             <= ACT_NO;
        end else begin
            safe_input_mode_setting  <= next_mode;
            safety_switch            <= next_safety_switch;
            monitor_switch           <= next_monitor_switch;
            ext_trip                 <= next_ext_trip;
            input3_function_select   <= next_in3_fn;
            input4_function_select   <= next_in4_fn;
            output11_function_select <= next_out11_fn;
            in3_active               <= next_in3_act;
            in4_active               <= next_in4_act;
            out11_active             <= next_out11_act;
        end
    end

    // ****************************************
    // channel sampling
    // ****************************************
    logic chan_a_sync;
    logic chan_b_sync;

    // synced copies serve trip, monitor, the one-channel interrupt and the status read
    sto_sync u_sync_a (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (safe_channel_a_i),
        .sync_o     (chan_a_sync)
    );

    sto_sync u_sync_b (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (safe_channel_b_i),
        .sync_o     (chan_b_sync)
    );

    // ****************************************
    // gating cut, combinational on raw pins
    // ****************************************
    // no clock in the path, so cut-off is far below the time limit
    logic interlock_active;
    logic tripped;

    assign interlock_active = safety_switch;
    assign gate_enable_o    = gate_run_i & ~tripped &
                              (~interlock_active | (safe_channel_a_i & safe_channel_b_i));

    // ****************************************
    // stop and trip state machine
    // ****************************************
    sto_state_type state;
    sto_state_type next_state;
    logic          both_on;
    logic          any_off;

    assign both_on = chan_a_sync & chan_b_sync;
    assign any_off = interlock_active & ~both_on;

    always_comb begin
        next_state = state;
        unique case (state)
            STO_RUN: begin
                if (any_off && safe_input_mode_setting == MODE_TRIP) begin
                    next_state = STO_TRIPPED;
                end else if (any_off) begin
                    next_state = STO_STOPPED;
                end
            end
            STO_STOPPED: begin
                if (!any_off) begin
                    next_state = STO_RUN;
                end else if (safe_input_mode_setting == MODE_TRIP) begin
                    next_state = STO_TRIPPED;
                end
            end
            STO_TRIPPED: begin
                // trip is held until software clears it with channels closed
                if (trip_clr_req && !any_off) begin
                    next_state = STO_RUN;
                end
            end
            default: next_state = STO_RUN;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= STO_RUN;
        end else begin
            state <= next_state;
        end
    end

    assign tripped = (state == STO_TRIPPED);

    // ****************************************
    // trip code and monitor output
    // ****************************************
    logic [7:0] trip_code;
    logic [7:0] next_trip_code;
    logic       monitor;
    logic       next_monitor;

    always_comb begin
        if (tripped) begin
            next_trip_code = SAFE_STOP_TRIP_CODE;
        end else if (ext_trip) begin
            next_trip_code = EXTERNAL_TRIP_CODE;
        end else begin
            next_trip_code = TRIP_NONE;
        end
        // conducts only with both channels open
        next_monitor = monitor_switch & ~chan_a_sync & ~chan_b_sync;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            trip_code <= TRIP_NONE;
            monitor   <= 1'b0;
        end else begin
            trip_code <= next_trip_code;
            monitor   <= next_monitor;
        end
    end

    assign trip_code_o          = trip_code;
    assign device_monitor_out_o = monitor;

    // ****************************************
    // interrupts
    // ****************************************
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic             state_run;
    logic             prev_run;

    assign state_run = (state == STO_RUN);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prev_run <= 1'b1;
        end else begin
            prev_run <= state_run;
        end
    end

    always_comb begin
        irq_event               = '0;
        irq_event[IRQ_TRIP]     = (next_state == STO_TRIPPED) & ~tripped;
        irq_event[IRQ_CUT]      = prev_run & ~state_run;
        irq_event[IRQ_ONE_CHAN] = interlock_active & (chan_a_sync ^ chan_b_sync);
    end

    sto_irq u_irq (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .event_i    (irq_event),
        .clear_i    (wr_access && sto_hit(paddr, STO_IRQ_CL_OFF) ? pwdata[IRQ_W-1:0] : '0),
        .en_we_i    (wr_access && sto_hit(paddr, STO_IRQ_EN_OFF)),
        .en_wdata_i (pwdata[IRQ_W-1:0]),
        .status_o   (irq_status),
        .enable_o   (irq_enable),
        .irq_o      (irq_o)
    );

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] next_prdata;
    logic [31:0] prdata_q;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_access) begin
            if (sto_hit(paddr, STO_CTRL_OFF)) begin
                next_prdata[CTRL_MODE_LSB +: 2] = safe_input_mode_setting;
                next_prdata[CTRL_SAFE_SW]       = safety_switch;
                next_prdata[CTRL_MON_SW]        = monitor_switch;
                next_prdata[CTRL_EXT_TRIP]      = ext_trip;
            end else if (sto_hit(paddr, STO_STATUS_OFF)) begin
                next_prdata[2:0]  = state;
                next_prdata[3]    = chan_a_sync;
                next_prdata[4]    = chan_b_sync;
                next_prdata[5]    = gate_enable_o;
                next_prdata[6]    = monitor;
                next_prdata[15:8] = trip_code;
            end else if (sto_hit(paddr, STO_TERM_OFF)) begin
                next_prdata[TERM_IN3_FN_LSB +: 8]   = input3_function_select;
                next_prdata[TERM_IN4_FN_LSB +: 8]   = input4_function_select;
                next_prdata[TERM_OUT11_FN_LSB +: 8] = output11_function_select;
                next_prdata[TERM_IN3_ACT]           = in3_active;
                next_prdata[TERM_IN4_ACT]           = in4_active;
                next_prdata[TERM_OUT11_ACT]         = out11_active;
            end else if (sto_hit(paddr, STO_IRQ_ST_OFF)) begin
                next_prdata[IRQ_W-1:0] = irq_status;
            end else if (sto_hit(paddr, STO_IRQ_EN_OFF)) begin
                next_prdata[IRQ_W-1:0] = irq_enable;
            end
        end
    end

    // read data is combinational within the access phase
    assign prdata_q = next_prdata;
    assign prdata   = prdata_q;

endmodule

/* verif/sto_relay_model.sv */
`timescale 1ns/10ps
module sto_relay_model (
    // clock
    input  wire logic core_clk_i,
    // demands from the bench
    input  wire logic want_a_i,
    input  wire logic want_b_i,
    input  wire logic estop_i,
    // current to the drive
    output logic      chan_a_o,
    output logic      chan_b_o
);
    // contacts move on the edge, so the drive sees clean steps
    always_ff @(posedge core_clk_i) begin
        chan_a_o <= want_a_i && !estop_i;
        chan_b_o <= want_b_i && !estop_i;
    end
endmodule

/* verif/sto_interlock_asserts.sv */
`timescale 1ns/10ps
module sto_chk
    import sto_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // drive side
    input wire logic        safe_channel_a_i,
    input wire logic        safe_channel_b_i,
    input wire logic        gate_run_i,
    input wire logic        gate_enable_o,
    input wire logic        device_monitor_out_o,
    input wire logic [7:0]  trip_code_o,
    input wire logic        irq_o
);
    // ****************************************
    // shadow of the control word
    // ****************************************
    logic [4:0] ctrl;
    logic [4:0] next_ctrl;
    logic       wr_ctl;
    logic       clr_wr;
    logic       rd_term;
    logic       both_on;
    logic       both_off;
    logic       tripped;
    always_comb begin
        wr_ctl    = psel && penable && pwrite && pready && paddr == STO_CTRL_OFF;
        clr_wr    = wr_ctl && pwdata[CTRL_TRIP_CLR];
        rd_term   = psel && penable && !pwrite && paddr == STO_TERM_OFF;
        both_on   = safe_channel_a_i && safe_channel_b_i;
        both_off  = !safe_channel_a_i && !safe_channel_b_i;
        tripped   = trip_code_o == SAFE_STOP_TRIP_CODE;
        next_ctrl = rst_i ? 5'h00 : (wr_ctl ? pwdata[4:0] : ctrl);
    end
    always_ff @(posedge core_clk_i) begin
        ctrl <= next_ctrl;
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    gate_cut_a:
        assert property (ctrl[CTRL_SAFE_SW] && !both_on |-> !gate_enable_o) else $error("gating with open channel");
    gate_allow_a:
        assert property (gate_run_i && both_on && $past(both_on, 3) && !tripped && !$past(tripped)
            |-> gate_enable_o) else $error("gating blocked");
    mon_level_a:
        assert property (device_monitor_out_o == ($past(ctrl[CTRL_MON_SW]) && $past(both_off, 3)))
        else $error("monitor level wrong");
    trip_set_a:
        assert property (ctrl[CTRL_SAFE_SW] && ctrl[1:0] == MODE_TRIP && $fell(both_on) |-> ##[1:6] tripped)
        else $error("no safe-stop trip");
    no_trip_a:
        assert property (ctrl[1:0] == MODE_NO_TRIP && $past(ctrl[1:0], 2) == MODE_NO_TRIP
            && $past(ctrl[1:0], 5) == MODE_NO_TRIP |-> !$rose(tripped)) else $error("trip in no-trip mode");
    code_hold_a:
        assert property (tripped && ctrl[CTRL_EXT_TRIP] && !clr_wr && !$past(clr_wr) |=> tripped)
        else $error("safe-stop code lost");
    term_in_a:
        assert property (rd_term && ctrl[CTRL_SAFE_SW] && $past(ctrl[CTRL_SAFE_SW])
            |-> prdata[15:0] == {FN_SAFE_B, FN_SAFE_A} && prdata[25:24] == 2'h3) else $error("inputs not locked");
    term_out_a:
        assert property (rd_term && ctrl[CTRL_MON_SW] && $past(ctrl[CTRL_MON_SW])
            |-> prdata[23:16] == FN_DEV_MON && prdata[26] == ACT_NO) else $error("output not locked");
    cover property (tripped);
    cover property (device_monitor_out_o);
    cover property (irq_o);
endmodule

bind sto_interlock sto_chk sto_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .safe_channel_a_i(safe_channel_a_i), .safe_channel_b_i(safe_channel_b_i),
    .gate_run_i(gate_run_i), .gate_enable_o(gate_enable_o), .device_monitor_out_o(device_monitor_out_o),
    .trip_code_o(trip_code_o), .irq_o(irq_o));

/* verif/sto_interlock_tb.sv */
`timescale 1ns/10ps
module sto_interlock_tb import sto_pkg::*;;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err, chan_a, chan_b, gate, mon, irq;
    logic        want_a = 1'b1, want_b = 1'b1, estop = 1'b0, run = 1'b1;
    logic [7:0]  code;
    logic [15:0] seed = 16'h5913;
    int          mismatches = 0, checks = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    sto_relay_model sto_relay_model_inst (.core_clk_i(core_clk_i), .want_a_i(want_a), .want_b_i(want_b),
        .estop_i(estop), .chan_a_o(chan_a), .chan_b_o(chan_b));
    sto_interlock sto_interlock_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .safe_channel_a_i(chan_a), .safe_channel_b_i(chan_b), .gate_run_i(run), .gate_enable_o(gate),
        .device_monitor_out_o(mon), .trip_code_o(code), .irq_o(irq));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // terminal word for given switch states
    function automatic logic [31:0] term_exp(input logic s, input logic m);
        return {5'h0, ACT_NO, s, s, m ? FN_DEV_MON : FN_NONE, s ? FN_SAFE_B : FN_NONE, s ? FN_SAFE_A : FN_NONE};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; no wait count assumed, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(20000 * 5);
        mismatches++;
        final_report();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, STO_TERM_OFF, 32'h0);
        check(q, term_exp(1'b0, 1'b0));
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        check(q, 32'h0);
        apb(1'b1, STO_CTRL_OFF, 32'h0c);
        apb(1'b1, STO_TERM_OFF, 32'h0);
        apb(1'b0, STO_TERM_OFF, 32'h0);
        check(q, term_exp(1'b1, 1'b1));
        apb(1'b1, STO_IRQ_EN_OFF, 32'h7);
        // the four proof-test pairs first, then random pairs
        for (int i = 0; i < 44; i++) begin
            seed = lfsr(seed);
            want_a <= (i < 4) ? i[0] : seed[0];
            want_b <= (i < 4) ? i[1] : seed[1];
            run <= (i < 4) || seed[2];
            repeat (5) @(posedge core_clk_i);
            check({30'h0, gate, mon}, {30'h0, run && want_a && want_b, !want_a && !want_b});
            check({24'h0, code}, {24'h0, TRIP_NONE});
        end
        want_a <= 1'b1;
        want_b <= 1'b1;
        run <= 1'b1;
        apb(1'b0, STO_IRQ_ST_OFF, 32'h0);
        check({31'h0, q[IRQ_ONE_CHAN] & irq}, 32'h1);
        apb(1'b1, STO_IRQ_EN_OFF, 32'h0);
        @(posedge core_clk_i);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, STO_IRQ_CL_OFF, 32'h7);
        apb(1'b1, STO_IRQ_EN_OFF, 32'h7);
        apb(1'b0, STO_IRQ_ST_OFF, 32'h0);
        check({q[31:1], irq}, 32'h0);
        // external trip, then an emergency stop on top of it
        apb(1'b1, STO_CTRL_OFF, 32'h1d);
        repeat (3) @(posedge core_clk_i);
        check({24'h0, code}, {24'h0, EXTERNAL_TRIP_CODE});
        estop <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        check({31'h0, gate}, 32'h0);
        repeat (6) @(posedge core_clk_i);
        check({24'h0, code}, {24'h0, SAFE_STOP_TRIP_CODE});
        // tripped, both open: monitor conducts, gating off
        apb(1'b0, STO_STATUS_OFF, 32'h0);
        check(q, {16'h0, SAFE_STOP_TRIP_CODE, 8'h44});
        apb(1'b0, STO_IRQ_ST_OFF, 32'h0);
        check({q[31:1], q[0] & irq}, (32'h1 << IRQ_TRIP) | (32'h1 << IRQ_CUT));
        estop <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        check({31'h0, gate}, 32'h0);
        apb(1'b1, STO_CTRL_OFF, 32'h2c);
        repeat (2) @(posedge core_clk_i);
        check({23'h0, gate, code}, {23'h0, 1'b1, TRIP_NONE});
        apb(1'b1, STO_CTRL_OFF, 32'h0);
        apb(1'b0, STO_TERM_OFF, 32'h0);
        check(q, term_exp(1'b0, 1'b0));
        final_report();
    end
endmodule
